// >>> inc/spp_pkg.sv
/*
 * constants and types shared by the supply-pulse threshold programmer.
 * assumes a single 20 MHz clock domain and APB register access.
 */
`default_nettype none

package spp_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 20; // core clock rate
	localparam int unsigned MIN_PULSE_NS = 20000; // least on time of any coded pulse
	localparam int unsigned LONG_PULSE_NS = 100000; // least on time of a fuse pulse
	localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LONG_PULSE_CYC = (LONG_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 12; // width counter, holds LONG_PULSE_CYC
	localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_PULSE_CYC);
	localparam logic [CNT_W-1:0] LONG_CNT = CNT_W'(LONG_PULSE_CYC);

	// ----------------------------------------------------------------
	// trim code and addressing
	// ----------------------------------------------------------------
	localparam int CODE_W = 6; // calibration code bits
	localparam int CODE_STEPS = 64; // calibration steps
	localparam int FUSE_W = 7; // six code fuses plus lock fuse
	localparam int LOCK_BIT = 6; // lock position in fuse vectors
	localparam int ADDR_W = 7; // address counter width
	localparam logic [ADDR_W-1:0] KEY_MIN_MIDS = 7'h07; // least mids inside the key
	localparam logic [ADDR_W-1:0] FIRST_ADDR = 7'h01; // address of code bit 0
	localparam logic [ADDR_W-1:0] LOCK_ADDR = 7'h41; // address of the lock fuse
	localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f; // counter saturates here

	// ----------------------------------------------------------------
	// magnetic thresholds, in step_resolution units
	// ----------------------------------------------------------------
	localparam int FIELD_W = 8;
	localparam logic [FIELD_W-1:0] OP_BASE_STEP = 8'h10; // operate_threshold at code 0
	localparam logic [FIELD_W-1:0] HYST_STEPS = 8'h02; // threshold_hysteresis

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] STATUS_OFS = 12'h000; // read only
	localparam logic [APB_AW-1:0] CFG_OFS = 12'h004; // read write
	localparam logic [APB_AW-1:0] FUSE_OFS = 12'h008; // read only
	localparam int CFG_PROG_EN_BIT = 0; // accept pulse programming
	localparam int CFG_INVERT_BIT = 1; // invert switch output
	localparam logic [1:0] CFG_RESET = 2'h1;
	localparam int ST_CODE_LSB = 0; // status: effective code [5:0]
	localparam int ST_LOCK_BIT = 6; // status: lock fuse sensed
	localparam int ST_ADDR_MODE_BIT = 7; // status: addressing mode entered
	localparam int ST_ACTIVE_BIT = 8; // status: switch active
	localparam int ST_ADDR_LSB = 9; // status: address counter [15:9]
	localparam int FU_SENSE_LSB = 0; // fuse: sensed fuses [6:0]
	localparam int FU_PROV_LSB = 8; // fuse: provisional bits [14:8]

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_WAIT_KEY, ST_KEY_COUNT, ST_ADDR} spp_state_t;

	typedef struct packed {
		logic mid; // finished count_level pulse
		logic high_short; // finished short delimit_fuse_level pulse
		logic high_long; // finished long delimit_fuse_level pulse
	} spp_pulse_t;

endpackage

`default_nettype wire

// >>> hw/spp_pulse_class.sv
/*
 * classifies supply pulses by peak level and on time.
 * assumes comparator levels already synchronised to pclk.
 */
`default_nettype none

module spp_pulse_class (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// synchronised level comparators
	input wire logic above_count,
	input wire logic above_delimit,
	// classified pulse, one cycle at pulse end
	output spp_pkg::spp_pulse_t pulse_ff
);

	logic in_pulse; // supply above hold_level band
	logic was_in_ff; // in_pulse one cycle ago
	logic seen_high_ff; // pulse reached delimit_fuse_level
	logic [spp_pkg::CNT_W-1:0] width_ff; // total on time, saturating
	logic [spp_pkg::CNT_W-1:0] high_ff; // time at high level, saturating
	logic pulse_end;

	assign in_pulse = above_count | above_delimit;
	assign pulse_end = was_in_ff & ~in_pulse;

	// ----------------------------------------------------------------
	// on time counters
	// ----------------------------------------------------------------
	// counters restart at each rising edge so one pulse never leaks into the next
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			was_in_ff <= 1'b0;
			seen_high_ff <= 1'b0;
			width_ff <= '0;
			high_ff <= '0;
		end
		else
		begin
			was_in_ff <= in_pulse;
			if (in_pulse && !was_in_ff)
			begin
				// new pulse
				seen_high_ff <= above_delimit;
				width_ff <= spp_pkg::CNT_W'(1);
				high_ff <= above_delimit ? spp_pkg::CNT_W'(1) : '0;
			end
			else if (in_pulse)
			begin
				seen_high_ff <= seen_high_ff | above_delimit;
				if (width_ff != spp_pkg::LONG_CNT)
					width_ff <= width_ff + spp_pkg::CNT_W'(1);
				if (above_delimit && high_ff != spp_pkg::LONG_CNT)
					high_ff <= high_ff + spp_pkg::CNT_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// classification at falling edge
	// ----------------------------------------------------------------
	// pulses under the least on time are noise and produce nothing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pulse_ff <= '0;
		else
		begin
			pulse_ff <= '0;
			if (pulse_end)
			begin
				if (seen_high_ff)
				begin
					pulse_ff.high_long <= (high_ff >= spp_pkg::LONG_CNT);
					pulse_ff.high_short <= (high_ff >= spp_pkg::MIN_CNT) && (high_ff < spp_pkg::LONG_CNT);
				end
				else
					pulse_ff.mid <= (width_ff >= spp_pkg::MIN_CNT);
			end
		end
	end

endmodule

`default_nettype wire

// >>> hw/spp_programmer.sv
/*
 * trim programming and switch logic of a pulse-programmed magnetic switch.
 * assumes digital comparator levels for the supply pin, a field sample in
 * step units on pclk, fuse sense lines, and an APB master.
 */
// Decided for this implementation: the APB slave port and the placing of the registers.
// Notes on behaviour
// - threshold range spans sixty-four equal steps
// - six code bits, each separately settable
// - hold level keeps volatile bits
// - mid pulse advances address counter
// - short high pulse ends mid run
// - long high pulse blows addressed fuse
// - supply near zero clears bits, counter
// - same sequence; provisional omits fuse pulse
// - blown fuse reads permanently set
// - lock fuse blocks further programming
// - trial bits retry freely, output follows
// - release equals operate minus hysteresis
// - output switches with hysteresis loop
// - key: short high, seven mids, short; the decoder accepts seven or more mids before the closing short
// - mid count selects target bit address
// - lock fuse is address sixty-five
// - unset bits evaluate as zero
`default_nettype none

module spp_programmer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spp_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// supply comparators, asynchronous
	input wire logic supply_present,
	input wire logic at_count_level,
	input wire logic at_delimit_level,
	// fuse array
	input wire logic [spp_pkg::FUSE_W-1:0] fuse_sense,
	output logic [spp_pkg::FUSE_W-1:0] fuse_blow,
	// magnetic path
	input wire logic [spp_pkg::FIELD_W-1:0] field_step,
	output logic [spp_pkg::FIELD_W-1:0] operate_threshold,
	output logic [spp_pkg::FIELD_W-1:0] release_threshold,
	output logic switch_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [9:0] sync1_ff; // first synchroniser stage
	logic [9:0] sync2_ff; // second stage, the only one read
	logic supply_s; // supply above zero
	logic count_s; // supply at count_level or above
	logic delimit_s; // supply at delimit_fuse_level
	logic [spp_pkg::FUSE_W-1:0] fuse_s; // sensed blown fuses
	spp_pkg::spp_pulse_t pulse; // classified pulse
	logic any_high; // short or long high pulse
	spp_pkg::spp_state_t state_ff; // sequence state
	spp_pkg::spp_state_t nxt_state;
	logic [spp_pkg::ADDR_W-1:0] addr_ff; // mid pulse counter
	logic [spp_pkg::ADDR_W-1:0] nxt_addr;
	logic [spp_pkg::FUSE_W-1:0] prov_ff; // provisional bitfields
	logic [spp_pkg::FUSE_W-1:0] set_vec; // bit addressed by a delimit
	logic [spp_pkg::FUSE_W-1:0] fuse_blow_ff;
	logic [spp_pkg::CODE_W-1:0] code; // effective calibration code
	logic locked; // lock fuse blown
	logic accept; // programming allowed
	logic [1:0] cfg_ff; // software configuration
	logic [spp_pkg::FIELD_W-1:0] op_ff;
	logic [spp_pkg::FIELD_W-1:0] rp_ff;
	logic active_ff; // switch state
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic setup_ph; // apb setup cycle
	logic wr_cfg; // write to configuration takes effect
	logic addr_hit; // mapped address

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// every pin-side level passes two flops before use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= {fuse_sense, at_delimit_level, at_count_level, supply_present};
			sync2_ff <= sync1_ff;
		end
	end

	assign supply_s = sync2_ff[0];
	assign count_s = sync2_ff[1];
	assign delimit_s = sync2_ff[2];
	assign fuse_s = sync2_ff[9:3];

	// ----------------------------------------------------------------
	// pulse classifier
	// ----------------------------------------------------------------
	spp_pulse_class u_class (
		.pclk(pclk),
		.presetn(presetn),
		.above_count(count_s),
		.above_delimit(delimit_s),
		.pulse_ff(pulse)
	);

	assign any_high = pulse.high_short | pulse.high_long;
	assign locked = fuse_s[spp_pkg::LOCK_BIT];
	assign accept = cfg_ff[spp_pkg::CFG_PROG_EN_BIT] & ~locked;

	// ----------------------------------------------------------------
	// sequence decoder
	// ----------------------------------------------------------------
	// the key must be rebuilt before every address so noise cannot program
	always_comb
	begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		set_vec = '0;
		if (!accept)
		begin
			// ignore sequences while locked or disabled
			nxt_state = spp_pkg::ST_WAIT_KEY;
			nxt_addr = '0;
		end
		else
		begin
			unique case (state_ff)
				spp_pkg::ST_WAIT_KEY:
				begin
					// first short high opens the key
					if (pulse.high_short)
					begin
						nxt_state = spp_pkg::ST_KEY_COUNT;
						nxt_addr = '0;
					end
				end
				spp_pkg::ST_KEY_COUNT:
				begin
					if (pulse.mid && addr_ff != spp_pkg::ADDR_MAX)
						nxt_addr = addr_ff + spp_pkg::ADDR_W'(1);
					else if (pulse.high_short && addr_ff >= spp_pkg::KEY_MIN_MIDS)
					begin
						// key complete, addressing mode
						nxt_state = spp_pkg::ST_ADDR;
						nxt_addr = '0;
					end
					else if (pulse.high_short)
						nxt_addr = '0; // too few mids, treat as new key start
					else if (pulse.high_long)
					begin
						nxt_state = spp_pkg::ST_WAIT_KEY;
						nxt_addr = '0;
					end
				end
				spp_pkg::ST_ADDR:
				begin
					if (pulse.mid && addr_ff != spp_pkg::ADDR_MAX)
						nxt_addr = addr_ff + spp_pkg::ADDR_W'(1);
					else if (any_high)
					begin
						// delimit: address selects one bitfield
						if (addr_ff == spp_pkg::LOCK_ADDR)
							set_vec[spp_pkg::LOCK_BIT] = 1'b1;
						else if (addr_ff >= spp_pkg::FIRST_ADDR &&
							addr_ff < spp_pkg::FIRST_ADDR + spp_pkg::ADDR_W'(spp_pkg::CODE_W))
							set_vec[3'(addr_ff - spp_pkg::FIRST_ADDR)] = 1'b1;
						nxt_state = spp_pkg::ST_WAIT_KEY;
						nxt_addr = '0;
					end
				end
			endcase
		end
	end

	// sequence state; loss of supply wipes it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= spp_pkg::ST_WAIT_KEY;
			addr_ff <= '0;
		end
		else if (!supply_s)
		begin
			state_ff <= spp_pkg::ST_WAIT_KEY;
			addr_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
		end
	end

	// provisional bitfields, kept while supply stays at hold_level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prov_ff <= '0;
		else if (!supply_s)
			prov_ff <= '0;
		else
			prov_ff <= prov_ff | set_vec;
	end

	// fuse blow strobe only for a long delimit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fuse_blow_ff <= '0;
		else if (pulse.high_long && supply_s)
			fuse_blow_ff <= set_vec;
		else
			fuse_blow_ff <= '0;
	end

	assign fuse_blow = fuse_blow_ff;

	// ----------------------------------------------------------------
	// thresholds and switch
	// ----------------------------------------------------------------
	// blown fuse forces the bit, unset bits stay zero
	assign code = prov_ff[spp_pkg::CODE_W-1:0] | fuse_s[spp_pkg::CODE_W-1:0];

	// thresholds follow the code every cycle so trials show at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_ff <= spp_pkg::OP_BASE_STEP;
			rp_ff <= spp_pkg::OP_BASE_STEP - spp_pkg::HYST_STEPS;
		end
		else
		begin
			op_ff <= spp_pkg::OP_BASE_STEP + spp_pkg::FIELD_W'(code);
			rp_ff <= spp_pkg::OP_BASE_STEP + spp_pkg::FIELD_W'(code) - spp_pkg::HYST_STEPS;
		end
	end

	assign operate_threshold = op_ff;
	assign release_threshold = rp_ff;

	// hysteresis: on at operate, off only below release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			active_ff <= 1'b0;
		else if (!active_ff && field_step >= op_ff)
			active_ff <= 1'b1;
		else if (active_ff && field_step < rp_ff)
			active_ff <= 1'b0;
	end

	assign switch_out = active_ff ^ cfg_ff[spp_pkg::CFG_INVERT_BIT];

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign setup_ph = psel & ~penable;
	assign addr_hit = (paddr == spp_pkg::STATUS_OFS) || (paddr == spp_pkg::CFG_OFS) ||
		(paddr == spp_pkg::FUSE_OFS);
	assign wr_cfg = psel & penable & pwrite & (paddr == spp_pkg::CFG_OFS);

	// configuration register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_ff <= spp_pkg::CFG_RESET;
		else if (wr_cfg)
			cfg_ff <= pwdata[1:0];
	end

	// read data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end
		else if (setup_ph)
		begin
			pslverr_ff <= ~addr_hit;
			prdata_ff <= '0;
			if (!pwrite)
			begin
				unique case (paddr)
					spp_pkg::STATUS_OFS:
					begin
						prdata_ff[spp_pkg::ST_CODE_LSB +: spp_pkg::CODE_W] <= code;
						prdata_ff[spp_pkg::ST_LOCK_BIT] <= locked;
						prdata_ff[spp_pkg::ST_ADDR_MODE_BIT] <= (state_ff == spp_pkg::ST_ADDR);
						prdata_ff[spp_pkg::ST_ACTIVE_BIT] <= active_ff;
						prdata_ff[spp_pkg::ST_ADDR_LSB +: spp_pkg::ADDR_W] <= addr_ff;
					end
					spp_pkg::CFG_OFS:
						prdata_ff[1:0] <= cfg_ff;
					spp_pkg::FUSE_OFS:
					begin
						prdata_ff[spp_pkg::FU_SENSE_LSB +: spp_pkg::FUSE_W] <= fuse_s;
						prdata_ff[spp_pkg::FU_PROV_LSB +: spp_pkg::FUSE_W] <= prov_ff;
					end
					default:
						prdata_ff <= '0; // unmapped reads zero
				endcase
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel & penable & pslverr_ff;

endmodule

`default_nettype wire

// >>> bench/spp_checker.sv
/* port assertions for the supply-pulse programmer.
   assumes one pclk domain and the top module's ports. */
`default_nettype none

module spp_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb write side, for the invert mirror
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spp_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	// supply and fuses
	input wire logic supply_present,
	input wire logic [spp_pkg::FUSE_W-1:0] fuse_sense,
	input wire logic [spp_pkg::FUSE_W-1:0] fuse_blow,
	// magnetic path
	input wire logic [spp_pkg::FIELD_W-1:0] field_step,
	input wire logic [spp_pkg::FIELD_W-1:0] operate_threshold,
	input wire logic [spp_pkg::FIELD_W-1:0] release_threshold,
	input wire logic switch_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [7:0] code; // code recovered from operate
	logic act; // switch state without inversion
	logic inv_ff; // mirror of the invert bit
	logic [3:0] age_ff; // cycles since fuse_sense moved
	logic [6:0] sense_ff; // last fuse_sense
	assign code = operate_threshold - spp_pkg::OP_BASE_STEP;
	assign act = switch_out ^ inv_ff;

	// invert mirror, taken at the apb write edge
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			inv_ff <= 1'b0;
		else if (psel && penable && pwrite && paddr == spp_pkg::CFG_OFS)
			inv_ff <= pwdata[spp_pkg::CFG_INVERT_BIT];

	// age of the sensed fuse pattern, saturating
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sense_ff <= 7'h00;
			age_ff <= 4'h0;
		end
		else
		begin
			sense_ff <= fuse_sense;
			if (fuse_sense != sense_ff)
				age_ff <= 4'h0;
			else if (age_ff != 4'hf)
				age_ff <= age_ff + 4'h1;
		end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_release_tracks: assert property (release_threshold == operate_threshold - spp_pkg::HYST_STEPS)
		else $error("release threshold off operate");
	a_code_range: assert property (code <= 8'h3f)
		else $error("operate threshold outside code range");
	a_blow_single: assert property (fuse_blow != 7'h00 |-> $onehot(fuse_blow) ##1 fuse_blow == 7'h00)
		else $error("fuse blow not a single one-cycle pulse");
	a_fuse_holds_bit: assert property (age_ff >= 4'h8 |-> (code[5:0] & fuse_sense[5:0]) == fuse_sense[5:0])
		else $error("blown fuse missing from code");
	a_zero_clears: assert property (!supply_present [*6] |-> code[5:0] == fuse_sense[5:0])
		else $error("trial bits survive supply loss");
	a_lock_blocks: assert property (fuse_sense[spp_pkg::LOCK_BIT] [*8] |-> fuse_blow == 7'h00)
		else $error("fuse blown after lock");
	a_sw_operate: assert property ((field_step >= operate_threshold && $stable(inv_ff)) [*3] |-> act)
		else $error("switch not active above operate");
	a_sw_release: assert property ((field_step < release_threshold && $stable(inv_ff)) [*3] |-> !act)
		else $error("switch active below release");

	c_lock_blow: cover property (fuse_blow[spp_pkg::LOCK_BIT]);
	c_bit_blow: cover property (fuse_blow[0]);
	c_switch_on: cover property ($rose(act));
endmodule

bind spp_programmer spp_checker i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.supply_present(supply_present),
	.fuse_sense(fuse_sense),
	.fuse_blow(fuse_blow),
	.field_step(field_step),
	.operate_threshold(operate_threshold),
	.release_threshold(release_threshold),
	.switch_out(switch_out)
);

`default_nettype wire

// >>> bench/spp_prog_model.sv
/* external pulse programmer: drives the supply level comparators.
   assumes its tasks are called from one bench process. */
`default_nettype none

module spp_prog_model (
	// clock
	input wire logic pclk,
	// supply comparator levels
	output logic supply_present,
	output logic at_count_level,
	output logic at_delimit_level
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ON_CYC = 404; // count and short pulse, just over 20 us
	localparam int OFF_CYC = 404; // gap at hold_level
	localparam int LONG_CYC = 2100; // fuse pulse, over 100 us

	// idle at hold_level from time zero
	initial
	begin
		supply_present = 1'b1;
		at_count_level = 1'b0;
		at_delimit_level = 1'b0;
	end

	// one pulse, then back to hold_level
	task automatic pulse(input logic high, input int width);
		@(posedge pclk);
		at_count_level <= 1'b1;
		at_delimit_level <= high;
		repeat (width) @(posedge pclk);
		at_count_level <= 1'b0;
		at_delimit_level <= 1'b0;
		repeat (OFF_CYC) @(posedge pclk);
	endtask

	// key, address run, delimiter: one bit per call
	task automatic send_bit(input int addr, input logic blow);
		pulse(1'b1, ON_CYC);
		repeat (7) pulse(1'b0, ON_CYC);
		pulse(1'b1, ON_CYC);
		repeat (addr) pulse(1'b0, ON_CYC);
		pulse(1'b1, blow ? LONG_CYC : ON_CYC);
	endtask

	// key opening and a run of mids, left without its closing delimit
	task automatic key_start(input int mids);
		pulse(1'b1, ON_CYC);
		repeat (mids) pulse(1'b0, ON_CYC);
	endtask

	// supply to zero between sequences
	task automatic drop_supply();
		@(posedge pclk);
		supply_present <= 1'b0;
		repeat (20) @(posedge pclk);
		supply_present <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
endmodule

`default_nettype wire

// >>> bench/spp_programmer_tb.sv
/* self-checking bench for the supply-pulse programmer.
   assumes the pulse model and a fuse array kept here. */
`default_nettype none

module spp_programmer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 100000; // cycle ceiling of the run

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sup, cnt, dlm, switch_out, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [6:0] fuse_sense = 7'h00; // sensed fuses
	logic [6:0] blown = 7'h00; // every blow pulse seen
	logic [6:0] fuse_blow;
	logic [7:0] field_step, op_thr, rel_thr;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;

	spp_programmer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_present(sup), .at_count_level(cnt), .at_delimit_level(dlm), .fuse_sense(fuse_sense),
		.fuse_blow(fuse_blow), .field_step(field_step), .operate_threshold(op_thr),
		.release_threshold(rel_thr), .switch_out(switch_out));
	spp_prog_model i_prog (.pclk(pclk), .supply_present(sup), .at_count_level(cnt), .at_delimit_level(dlm));

	// clock and timeout
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			fails++;
			wrap_up();
		end
	end

	// fuse array: a blown fuse stays sensed
	always @(posedge pclk)
	begin
		fuse_sense <= fuse_sense | fuse_blow;
		blown <= blown | fuse_blow;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer, result in rdat and rerr
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// thresholds and status against a code
	task automatic chk_code(input logic [7:0] c);
		apb(1'b0, spp_pkg::STATUS_OFS, 32'h0);
		chk("status code", {26'h0, rdat[5:0]}, {24'h0, c});
		chk("operate", {24'h0, op_thr}, {24'h0, spp_pkg::OP_BASE_STEP + c});
		chk("release", {24'h0, rel_thr}, {24'h0, spp_pkg::OP_BASE_STEP + c - spp_pkg::HYST_STEPS});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_idle();
		apb(1'b0, spp_pkg::CFG_OFS, 32'h0);
		chk("cfg", rdat, 32'h1);
		apb(1'b1, spp_pkg::STATUS_OFS, 32'hffff_ffff); // read only
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", {31'h0, rerr}, 32'h1);
		chk("unmapped data", rdat, 32'h0);
		chk_code(8'h00);
	endtask

	// programming switched off: a key start must leave the decoder idle
	task automatic t_disabled();
		apb(1'b1, spp_pkg::CFG_OFS, 32'h0);
		i_prog.key_start(3);
		apb(1'b0, spp_pkg::STATUS_OFS, 32'h0);
		chk("status addr", {25'h0, rdat[15:9]}, 32'h0);
		apb(1'b1, spp_pkg::CFG_OFS, 32'h1);
	endtask

	task automatic t_trial();
		i_prog.send_bit(2, 1'b0);
		repeat (8) @(posedge pclk);
		chk_code(8'h02);
		chk("blown", {25'h0, blown}, 32'h0);
	endtask

	// hysteresis sweep at code 2, then inverted
	task automatic t_switch();
		logic [7:0] f [5] = '{8'h12, 8'h11, 8'h0f, 8'h11, 8'h12};
		logic e;
		e = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			field_step <= f[i];
			repeat (4) @(posedge pclk);
			e = (f[i] >= 8'h12) ? 1'b1 : (f[i] < 8'h10) ? 1'b0 : e;
			chk("switch", {31'h0, switch_out}, {31'h0, e});
		end
		apb(1'b1, spp_pkg::CFG_OFS, 32'h3);
		repeat (4) @(posedge pclk);
		chk("switch inverted", {31'h0, switch_out}, 32'h0);
		apb(1'b1, spp_pkg::CFG_OFS, 32'h1);
		field_step <= 8'h00;
	endtask

	task automatic t_perm();
		i_prog.send_bit(1, 1'b1);
		repeat (8) @(posedge pclk);
		chk("blown", {25'h0, blown}, 32'h1);
		chk_code(8'h03);
		i_prog.drop_supply();
		chk_code(8'h01);
		apb(1'b0, spp_pkg::FUSE_OFS, 32'h0);
		chk("fuse reg", {25'h0, rdat[6:0]}, 32'h1);
		chk("prov bits", {25'h0, rdat[14:8]}, 32'h0);
	endtask

	task automatic t_lock();
		i_prog.send_bit(65, 1'b1);
		repeat (8) @(posedge pclk);
		chk("blown", {25'h0, blown}, 32'h41);
		i_prog.send_bit(2, 1'b0);
		repeat (8) @(posedge pclk);
		chk_code(8'h01);
		chk("status lock", {31'h0, rdat[6]}, 32'h1);
	endtask

	// main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		field_step = 8'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		t_idle();
		t_disabled();
		t_trial();
		t_switch();
		t_perm();
		t_lock();
		wrap_up();
	end
endmodule

`default_nettype wire
